// ### rtl/trd_pkg.sv
package trd_pkg;

    // Register byte offsets on the APB slave.
    localparam logic [7:0]  TRD_OFS_INSTR   = 8'h00;
    localparam logic [7:0]  TRD_OFS_STATUS  = 8'h04;
    localparam logic [7:0]  TRD_OFS_POINTER = 8'h08;
    localparam logic [7:0]  TRD_OFS_LATCH   = 8'h0c;
    localparam logic [7:0]  TRD_OFS_RESULT  = 8'h10;

    // Opcode layout of the table-read instruction word.
    localparam int          TRD_OPC_MSB     = 15;
    localparam int          TRD_OPC_LSB     = 10;
    localparam logic [5:0]  TRD_OPC_CODE    = 6'h2a;
    localparam int          TRD_T_BIT       = 9;
    localparam int          TRD_I_BIT       = 8;
    localparam int          TRD_F_MSB       = 7;

    // File address of the program counter low byte.
    localparam logic [7:0]  TRD_PC_LOW_ADDR = 8'h02;

    // Status register bit positions.
    localparam int          TRD_ST_BUSY     = 0;
    localparam int          TRD_ST_DONE     = 1;
    localparam int          TRD_ST_ILLEGAL  = 2;
    localparam int          TRD_ST_CYC_LSB  = 4;

    // Q phases inside one instruction cycle.
    localparam int          TRD_PHASES      = 4;
    localparam int          TRD_Q1          = 0;
    localparam int          TRD_Q2          = 1;
    localparam int          TRD_Q3          = 2;
    localparam int          TRD_Q4          = 3;

    // Instruction cycle counts.
    localparam logic [1:0]  TRD_CYC_NORMAL  = 2'h2;
    localparam logic [1:0]  TRD_CYC_PC_LOW  = 2'h3;

    // Reset values and the pointer step.
    localparam logic [15:0] TRD_RST_WORD    = 16'h0000;
    localparam logic [7:0]  TRD_RST_BYTE    = 8'h00;
    localparam logic [31:0] TRD_RST_DATA    = 32'h0000_0000;
    localparam logic [15:0] TRD_PTR_STEP    = 16'h0001;

    // Execution state, one-hot.
    typedef enum logic [3:0] {
        TRD_ST_IDLE  = 4'b0001,
        TRD_ST_EXEC  = 4'b0010,
        TRD_ST_FETCH = 4'b0100,
        TRD_ST_DUMMY = 4'b1000
    } trd_state_e;

endpackage : trd_pkg

// ### rtl/trd_q_phase.sv
`timescale 1ns/10ps

// Generates the one-hot Q phase of the running instruction cycle.
module trd_q_phase
    import trd_pkg::*;
#(
    parameter int PHASES = TRD_PHASES
)
(
    // Clock and reset.
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Control.
    input  wire logic              run,
    // Phase output.
    output logic [PHASES-1:0]      phase
);

    localparam logic [PHASES-1:0] FIRST = {{(PHASES-1){1'b0}}, 1'b1};

    // Idle holds the first phase so a new instruction starts at once in Q1.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase <= FIRST;
        end
        else if (run)
        begin
            phase <= {phase[PHASES-2:0], phase[PHASES-1]};
        end
        else
        begin
            phase <= FIRST;
        end
    end

endmodule : trd_q_phase

// ### rtl/trd_table_read.sv
`timescale 1ns/10ps

module trd_table_read
    import trd_pkg::*;
(
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Program memory.
    output logic      [15:0] prog_addr,
    output logic             prog_addr_valid,
    output logic             prog_oe_n,
    input  wire logic [15:0] prog_data_in,
    // File register write port.
    output logic             file_wr_en,
    output logic      [7:0]  file_wr_addr,
    output logic      [7:0]  file_wr_data
);

    trd_state_e              state;
    logic [TRD_PHASES-1:0]   phase;
    logic                    busy;
    logic [15:0]             opcode;
    logic [15:0]             table_address_pointer;
    logic [15:0]             program_word_latch;
    logic [7:0]              read_byte;
    logic                    done;
    logic                    illegal;
    logic [1:0]              cycles_used;
    logic                    apb_setup;
    logic                    apb_fire;
    logic                    wr_fire;
    logic                    start;
    logic                    bad_opc;
    logic                    sel_high;
    logic                    do_incr;
    logic [7:0]              file_addr;
    logic                    dest_pc_low;
    logic                    fetch_q4;
    logic                    finish;
    logic                    mapped;
    logic [31:0]             rd_mux;
    wire [7:0] program_word_latch_high = program_word_latch[15:8];
    wire [7:0] program_word_latch_low  = program_word_latch[7:0];
    trd_q_phase #(
        .PHASES (TRD_PHASES)
    ) u_phase (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (busy),
        .phase   (phase)
    );

    // Operand fields of the captured instruction word.
    assign sel_high  = opcode[TRD_T_BIT];
    assign do_incr   = opcode[TRD_I_BIT];
    assign file_addr = opcode[TRD_F_MSB:0];
    assign dest_pc_low = (file_addr == TRD_PC_LOW_ADDR);

    // APB handshake terms; the access edge is the one with pready high.
    assign apb_setup = psel & penable & ~pready;
    assign apb_fire  = psel & penable & pready;
    assign wr_fire   = apb_fire & pwrite;
    // An instruction write starts only from idle; a busy core ignores it.
    // opcode match decode
    assign bad_opc   = (pwdata[TRD_OPC_MSB:TRD_OPC_LSB] != TRD_OPC_CODE);
    assign start     = wr_fire & (paddr == TRD_OFS_INSTR) & ~busy & ~bad_opc;
    assign fetch_q4  = (state == TRD_ST_FETCH) & phase[TRD_Q4];
    assign finish    = phase[TRD_Q4] & ((state == TRD_ST_DUMMY) | ((state == TRD_ST_FETCH) & ~dest_pc_low));

    // Sequencer over instruction cycles; each Q phase lasts one clock.
    // two or three cycles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= TRD_ST_IDLE;
            busy  <= 1'b0;
        end
        else
        begin
            case (state)
                TRD_ST_IDLE:
                begin
                    if (start)
                    begin
                        state <= TRD_ST_EXEC;
                        busy  <= 1'b1;
                    end
                end
                TRD_ST_EXEC:
                begin
                    if (phase[TRD_Q4])
                    begin
                        state <= TRD_ST_FETCH;
                    end
                end
                TRD_ST_FETCH:
                begin
                    if (phase[TRD_Q4])
                    begin
                        state <= dest_pc_low ? TRD_ST_DUMMY : TRD_ST_IDLE;
                        busy  <= dest_pc_low;
                    end
                end
                TRD_ST_DUMMY:
                begin
                    if (phase[TRD_Q4])
                    begin
                        state <= TRD_ST_IDLE;
                        busy  <= 1'b0;
                    end
                end
                default:
                begin
                    state <= TRD_ST_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end

    // Instruction word is kept for the whole execution and reads back.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            opcode <= TRD_RST_WORD;
        end
        else if (start)
        begin
            opcode <= pwdata[15:0];
        end
    end

    // Cycle one: latch byte read in Q2, staged in Q3, written in Q4.
    // Q phase activity
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            read_byte    <= TRD_RST_BYTE;
            file_wr_en   <= 1'b0;
            file_wr_addr <= TRD_RST_BYTE;
            file_wr_data <= TRD_RST_BYTE;
        end
        else
        begin
            if ((state == TRD_ST_EXEC) && phase[TRD_Q2])
            begin
                read_byte <= sel_high ? program_word_latch_high : program_word_latch_low;
            end
            if ((state == TRD_ST_EXEC) && phase[TRD_Q3])
            begin
                file_wr_en   <= 1'b1;
                file_wr_addr <= file_addr;
                file_wr_data <= read_byte;
            end
            else
            begin
                file_wr_en <= 1'b0;
            end
        end
    end

    // Cycle two drives the bus; the memory answers while the strobe is low.
    // address and strobe
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prog_addr       <= TRD_RST_WORD;
            prog_addr_valid <= 1'b0;
            prog_oe_n       <= 1'b1;
        end
        else
        begin
            if ((state == TRD_ST_FETCH) && phase[TRD_Q1])
            begin
                prog_addr       <= table_address_pointer;
                prog_addr_valid <= 1'b1;
            end
            else if (fetch_q4)
            begin
                prog_addr_valid <= 1'b0;
            end
            prog_oe_n <= ~((state == TRD_ST_FETCH) & phase[TRD_Q3]);
        end
    end

    // Latch reload at the end of the strobe; software may preload it when idle.
    // whole latch reload
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            program_word_latch <= TRD_RST_WORD;
        end
        else if (fetch_q4)
        begin
            program_word_latch <= prog_data_in;
        end
        else if (wr_fire && (paddr == TRD_OFS_LATCH) && !busy)
        begin
            program_word_latch <= pwdata[15:0];
        end
    end

    // Pointer moves on the same edge that reloads the latch, so the next
    // table read already sees the advanced address.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            table_address_pointer <= TRD_RST_WORD;
        end
        else if (fetch_q4 && do_incr)
        begin
            table_address_pointer <= table_address_pointer + TRD_PTR_STEP;
        end
        else if (wr_fire && (paddr == TRD_OFS_POINTER) && !busy)
        begin
            table_address_pointer <= pwdata[15:0];
        end
    end

    // Sticky status; a hardware set in the clearing cycle wins.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done        <= 1'b0;
            illegal     <= 1'b0;
            cycles_used <= 2'h0;
        end
        else
        begin
            if (finish)
            begin
                done        <= 1'b1;
                cycles_used <= dest_pc_low ? TRD_CYC_PC_LOW : TRD_CYC_NORMAL;
            end
            else if (wr_fire && (paddr == TRD_OFS_STATUS) && pwdata[TRD_ST_DONE])
            begin
                done <= 1'b0;
            end
            if (wr_fire && (paddr == TRD_OFS_INSTR) && !busy && bad_opc)
            begin
                illegal <= 1'b1;
            end
            else if (wr_fire && (paddr == TRD_OFS_STATUS) && pwdata[TRD_ST_ILLEGAL])
            begin
                illegal <= 1'b0;
            end
        end
    end

    // Read mux and address map check.
    always_comb
    begin
        mapped = 1'b1;
        rd_mux = TRD_RST_DATA;
        case (paddr)
            TRD_OFS_INSTR:   rd_mux[15:0] = opcode;
            TRD_OFS_STATUS:
            begin
                rd_mux[TRD_ST_BUSY]                    = busy;
                rd_mux[TRD_ST_DONE]                    = done;
                rd_mux[TRD_ST_ILLEGAL]                 = illegal;
                rd_mux[TRD_ST_CYC_LSB+1:TRD_ST_CYC_LSB] = cycles_used;
            end
            TRD_OFS_POINTER: rd_mux[15:0] = table_address_pointer;
            TRD_OFS_LATCH:   rd_mux[15:0] = program_word_latch;
            TRD_OFS_RESULT:  rd_mux[15:0] = {file_wr_addr, file_wr_data};
            default:         mapped = 1'b0;
        endcase
    end

    // One wait state: pready rises in the second access cycle, which keeps
    // every bus output registered.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= TRD_RST_DATA;
        end
        else
        begin
            pready  <= apb_setup;
            pslverr <= apb_setup & ~mapped;
            if (apb_setup && !pwrite)
            begin
                prdata <= rd_mux;
            end
        end
    end
    // Helper logic for the checks below.
    logic [3:0] busy_cnt;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_cnt <= 4'h0;
        end
        else
        begin
            busy_cnt <= start ? 4'h0 : (busy ? busy_cnt + 4'h1 : busy_cnt);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence fetch_end_s;
        (state == TRD_ST_FETCH) && phase[TRD_Q4];
    endsequence

    sequence write_slot_s;
        (state == TRD_ST_EXEC) && phase[TRD_Q4];
    endsequence

    hi_byte_copy_a: assert property (write_slot_s and sel_high |-> file_wr_en &&
        file_wr_data == program_word_latch_high) else $error("High latch byte not written.");
    lo_byte_copy_a: assert property (write_slot_s and !sel_high |-> file_wr_en &&
        file_wr_data == program_word_latch_low) else $error("Low latch byte not written.");
    latch_reload_a: assert property (fetch_end_s |=>
        program_word_latch == $past(prog_data_in)) else $error("Latch not reloaded.");
    ptr_incr_a: assert property (fetch_end_s and do_incr |=>
        table_address_pointer == $past(table_address_pointer) + TRD_PTR_STEP) else $error("Pointer not incremented.");
    ptr_hold_a: assert property ((state == TRD_ST_FETCH) && !do_incr |=>
        $stable(table_address_pointer)) else $error("Pointer changed without increment.");
    bad_opcode_a: assert property (wr_fire && paddr == TRD_OFS_INSTR && !busy && bad_opc |=>
        !busy && illegal) else $error("Bad opcode started execution.");
    cycle_count_a: assert property ($fell(busy) |->
        busy_cnt == (dest_pc_low ? 4'hc : 4'h8)) else $error("Wrong instruction length.");
    write_phase_a: assert property (file_wr_en |-> write_slot_s) else $error("File write outside Q4.");
    addr_drive_a: assert property ((state == TRD_ST_FETCH) && phase[TRD_Q2] |->
        prog_addr_valid && prog_addr == table_address_pointer) else $error("Pointer not on bus in Q2.");
    strobe_phase_a: assert property (!prog_oe_n |-> fetch_end_s ##1 prog_oe_n)
        else $error("Read strobe outside Q4.");
    ptr_wrap_a: assert property (fetch_end_s and do_incr && table_address_pointer == 16'hffff |=>
        table_address_pointer == TRD_RST_WORD) else $error("Pointer did not wrap.");

endmodule : trd_table_read

// ### tb/trd_prog_mem.sv
`timescale 1ns/10ps

// Program memory model; it answers at once while the read strobe is low.
module trd_prog_mem
#(
    parameter logic [15:0] KEY = 16'h3c5a
)
(
    // Program memory bus.
    input  wire logic [15:0] prog_addr,
    input  wire logic        prog_oe_n,
    output logic      [15:0] prog_data_in
);
    logic [15:0] last_word = 16'h0000;

    // Remember the last word so the idle bus can show its inverse.
    always @(negedge prog_oe_n)
        last_word = {prog_addr[7:0], prog_addr[15:8]} ^ KEY;

    // The word depends on the address, so a wrong address shows up in the data.
    // Outside the strobe the bus is not held, so stale data must never look valid.
    // strobe low, word out
    always_comb
    begin
        if (prog_oe_n === 1'b0)
            prog_data_in = {prog_addr[7:0], prog_addr[15:8]} ^ KEY;
        else
            prog_data_in = ~last_word;
    end
endmodule : trd_prog_mem

// ### tb/testbench.sv
`timescale 1ns/10ps

// Self-checking bench for the table-read block.
module testbench;
    import trd_pkg::*;

    localparam logic [15:0] MEM_KEY = 16'h3c5a;
    localparam int          LIMIT   = 20000;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] prog_addr;
    logic        prog_addr_valid;
    logic        prog_oe_n;
    logic [15:0] prog_data_in;
    logic        file_wr_en;
    logic [7:0]  file_wr_addr;
    logic [7:0]  file_wr_data;
    logic [31:0] rdata;
    logic        rerr;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
    logic [15:0] oe_addr;
    logic        oe_valid;
    int          num_errors = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          wr_cnt = 0;
    int          oe_cnt = 0;
    int          wr_cyc = 0;
    int          gap = 0;
    int          seed;

    always #2.5 pclk = ~pclk;

    trd_table_read i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .prog_addr(prog_addr), .prog_addr_valid(prog_addr_valid), .prog_oe_n(prog_oe_n),
        .prog_data_in(prog_data_in), .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr),
        .file_wr_data(file_wr_data));

    trd_prog_mem #(.KEY(MEM_KEY)) i_mem (.prog_addr(prog_addr), .prog_oe_n(prog_oe_n),
        .prog_data_in(prog_data_in));

    // Expected memory word, worked out independently of the model's code path.
    function automatic logic [15:0] mem_word(input logic [15:0] a);
        return {a[7:0], a[15:8]} ^ MEM_KEY;
    endfunction : mem_word

    // Instruction length in cycles: three when the destination is the program counter low byte.
    function automatic logic [31:0] exp_cycles(input logic [7:0] dest);
        return (dest == TRD_PC_LOW_ADDR) ? 32'h3 : 32'h2;
    endfunction : exp_cycles

    // Latch half that the instruction moves: the high byte when t is set.
    function automatic logic [7:0] exp_byte(input logic [15:0] word, input logic hi);
        return hi ? word[15:8] : word[7:0];
    endfunction : exp_byte

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // Compares a seen value with the expected one.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // One APB transfer; the request stands until pready is seen high at a rising edge.
    // Only the watchdog ends a wait that never gets its answer.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check(32'(n), 32'h2, "apb wait states");
    endtask : apb

    // Watches the file write port and the memory strobe; also cuts a hang short.
    always @(negedge pclk)
    begin
        cyc++;
        if (file_wr_en === 1'b1)
        begin
            wr_cnt++;
            wr_cyc = cyc;
            wr_addr = file_wr_addr;
            wr_data = file_wr_data;
        end
        if (prog_oe_n === 1'b0)
        begin
            oe_cnt++;
            gap = cyc - wr_cyc;
            oe_addr = prog_addr;
            oe_valid = prog_addr_valid;
        end
        if (cyc >= LIMIT)
        begin
            num_errors++;
            test_done();
        end
    end

    // Main sequence.
    initial
    begin
        logic [15:0] ptr;
        logic [15:0] lat;
        logic [7:0]  f;
        logic        t;
        logic        i;
        int          w0;
        int          o0;
        int          n;
        seed = 32'h67d316f1;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, TRD_OFS_POINTER, 32'h0);
        check(rdata, 32'h0, "pointer reset");
        check(32'(rerr), 32'h0, "mapped read error");
        apb(1'b0, TRD_OFS_STATUS, 32'h0);
        check(rdata, 32'h0, "status reset");
        apb(1'b0, 8'h20, 32'h0);
        check(32'(rerr), 32'h1, "unmapped error");
        $display("test reset and map done");
        for (int k = 0; k < 16; k++)
        begin
            ptr = 16'($random(seed));
            lat = 16'($random(seed));
            f = 8'($random(seed));
            t = k[0];
            i = k[1];
            if (k == 3)
                ptr = 16'hffff;
            if (k == 5)
                f = TRD_PC_LOW_ADDR;
            apb(1'b1, TRD_OFS_POINTER, {16'h0, ptr});
            apb(1'b1, TRD_OFS_LATCH, {16'h0, lat});
            w0 = wr_cnt;
            o0 = oe_cnt;
            apb(1'b1, TRD_OFS_INSTR, {16'h0, TRD_OPC_CODE, t, i, f});
            // A pointer write that lands while the core is busy must be ignored.
            if (k == 6)
                apb(1'b1, TRD_OFS_POINTER, 32'h0000_5a5a);
            n = 0;
            do
            begin
                apb(1'b0, TRD_OFS_STATUS, 32'h0);
                n++;
            end
            while (rdata[TRD_ST_BUSY] !== 1'b0 && n < 20);
            check(32'(rdata[TRD_ST_CYC_LSB+:2]), exp_cycles(f), "cycle count");
            check(32'(rdata[TRD_ST_DONE]), 32'h1, "done flag");
            check(32'(wr_cnt - w0), 32'h1, "file writes");
            check(32'(wr_addr), 32'(f), "file address");
            check(32'(wr_data), 32'(exp_byte(lat, t)), "file byte");
            check(32'(oe_cnt - o0), 32'h1, "strobe clocks");
            check(32'(gap), 32'h4, "strobe phase");
            check({15'h0, oe_valid, oe_addr}, {16'h1, ptr}, "memory address");
            apb(1'b0, TRD_OFS_RESULT, 32'h0);
            check(rdata, {16'h0, f, exp_byte(lat, t)}, "result word");
            apb(1'b0, TRD_OFS_LATCH, 32'h0);
            check(rdata, {16'h0, mem_word(ptr)}, "latch reload");
            apb(1'b0, TRD_OFS_POINTER, 32'h0);
            check(rdata, {16'h0, ptr + 16'(i)}, "pointer step");
            apb(1'b1, TRD_OFS_STATUS, 32'h2);
        end
        $display("test table reads done");
        // Each of the six opcode bits flipped in turn gives a word that must be refused.
        for (int j = 0; j < 6; j++)
        begin
            w0 = wr_cnt;
            apb(1'b1, TRD_OFS_INSTR, {16'h0, TRD_OPC_CODE ^ (6'h01 << j), 10'($random(seed))});
            repeat (14) @(posedge pclk);
            apb(1'b0, TRD_OFS_STATUS, 32'h0);
            check(32'(rdata[TRD_ST_ILLEGAL]), 32'h1, "bad opcode flag");
            check(32'(rdata[TRD_ST_BUSY]), 32'h0, "bad opcode busy");
            check(32'(wr_cnt - w0), 32'h0, "bad opcode write");
            apb(1'b1, TRD_OFS_STATUS, 32'h4);
        end
        $display("test bad opcodes done");
        test_done();
    end
endmodule : testbench
